// file: hw/rtc_cfg.svh
// constants for the clock-and-calendar control and calibration block
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// ************************************************************
// register offsets (byte addresses on the plain register port)
// ************************************************************
`define RTC_ADDR_W 8
`define RTC_CTRL_OFS 8'h00
`define RTC_TIME_OFS 8'h04

// ************************************************************
// control register field positions
// ************************************************************
`define RTC_CAL_MSB 25
`define RTC_CAL_LSB 16
`define RTC_ON_BIT 15
`define RTC_STOP_IN_IDLE_BIT 13
`define RTC_SEL_BIT 7
`define RTC_RUN_BIT 6
`define RTC_WREN_BIT 3
`define RTC_SYNC_BIT 2
`define RTC_HALF_BIT 1
`define RTC_OE_BIT 0

// seconds fields inside the time value register
`define RTC_SEC_MSB 14
`define RTC_SEC_LSB 8

// ************************************************************
// reset values
// ************************************************************
`define RTC_CTRL_RST 32'h0000_0000
`define RTC_CAL_RST 10'h000

// ************************************************************
// timing
// ************************************************************
`define RTC_XTAL_HZ 32768
`define RTC_SEC_PER_MIN 60
`define RTC_SYNC_WINDOW 32
`define RTC_CLK_PERIOD_NS 50
`define RTC_XTAL_TIMEOUT_NS 100000
`define RTC_XTAL_TIMEOUT_CYC (`RTC_XTAL_TIMEOUT_NS / `RTC_CLK_PERIOD_NS)

`endif

// file: hw/rtc_control_calibration.sv
// control register, calibration and output pin logic of the clock-and-calendar unit
//
// Function
// RULE_01: control bits 25:16 hold a signed ten-bit drift calibration value.
// RULE_02: positive value adds that many time-base pulses once per minute.
// RULE_03: negative value removes its magnitude in pulses once per minute.
// RULE_04: enable flag bit 15 turns the clock-and-calendar unit on or off.
// RULE_05: enable flag writes are ignored unless the value write enable reads one.
// RULE_06: stop-in-idle bit 13 cuts the bus clock to the unit during idle.
// RULE_07: select bit 7 routes seconds clock when one, alarm pulse when zero.
// RULE_08: pin carries the selected signal only while output enable bit 0 is one.
// RULE_09: read-only bit 6 shows whether the time-base clock is running.
// RULE_10: write enable bit 3 unlocks the time and date value registers.
// RULE_11: write enable can be set only while the unlock sequence is enabled.
// RULE_12: read-only bit 2 flags the rollover window where reads may be torn.
// RULE_13: software reads twice during that window and keeps matching results.
// RULE_14: read-only bit 1 is one in the second half of each second.
// RULE_15: writing the seconds fields clears the half-second flag.
// RULE_16: software avoids access right after clearing the enable flag at 1:1 divisor.
// RULE_17: unimplemented control bits read as zero.
// RULE_18: calibration and counters run from the 32.768 kHz crystal time base.
// RULE_19: reset clears every control field: disabled, uncalibrated, output off.
//
// Implementation choices: the strobed register port and the register offsets.
`include "rtc_cfg.svh"

module rtc_control_calibration #(
  parameter int ADDR_W = `RTC_ADDR_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // system inputs
  input wire logic i_xtal_tick,
  input wire logic i_unlock,
  input wire logic i_idle,
  input wire logic i_alarm_pulse,
  // towards the counters and the rest of the unit
  output logic o_unit_enable,
  output logic o_bus_clk_enable,
  output logic o_corr_tick,
  output logic o_minute,
  output logic o_time_wr,
  output logic [31:0] o_time_wdata,
  // output pin
  output logic o_rtc_pin
);

  rtc_pkg::rtc_ctrl_s ctrl_q;
  rtc_pkg::rtc_stat_s stat;
  logic [31:0] rdata_q;
  logic [31:0] ctrl_word;
  logic ctrl_wr;
  logic time_wr;
  logic sec_clear;
  logic pin_q;
  logic time_wr_q;
  logic [31:0] time_wdata_q;

  // ************************************************************
  // address decode
  // ************************************************************
  assign ctrl_wr = i_wr && i_addr == ADDR_W'(`RTC_CTRL_OFS);
  assign time_wr = i_wr && i_addr == ADDR_W'(`RTC_TIME_OFS);
  // a locked time write never reaches the counters, so it leaves the phase alone
  assign sec_clear = time_wr && ctrl_q.wren; // [RULE_15]

  // ************************************************************
  // control register, one process per field group
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ctrl_q.cal <= `RTC_CAL_RST; // [RULE_19]
    else if (ctrl_wr)
      ctrl_q.cal <= i_wdata[`RTC_CAL_MSB:`RTC_CAL_LSB]; // [RULE_01]
  end

  // enable is guarded by the write enable as it stands before this write
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ctrl_q.on <= 1'b0; // [RULE_19]
    else if (ctrl_wr && ctrl_q.wren)
      ctrl_q.on <= i_wdata[`RTC_ON_BIT]; // [RULE_05]
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl_q.stop_in_idle <= 1'b0; // [RULE_19]
      ctrl_q.sel <= 1'b0;
      ctrl_q.oe <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      ctrl_q.stop_in_idle <= i_wdata[`RTC_STOP_IN_IDLE_BIT];
      ctrl_q.sel <= i_wdata[`RTC_SEL_BIT];
      ctrl_q.oe <= i_wdata[`RTC_OE_BIT];
    end
  end

  // clearing is always allowed; setting needs the unlock sequence
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ctrl_q.wren <= 1'b0; // [RULE_19]
    else if (ctrl_wr && (!i_wdata[`RTC_WREN_BIT] || i_unlock))
      ctrl_q.wren <= i_wdata[`RTC_WREN_BIT]; // [RULE_11]
  end

  // ************************************************************
  // read path
  // ************************************************************
  always_comb
  begin
    ctrl_word = '0; // [RULE_17]
    ctrl_word[`RTC_CAL_MSB:`RTC_CAL_LSB] = ctrl_q.cal;
    ctrl_word[`RTC_ON_BIT] = ctrl_q.on;
    ctrl_word[`RTC_STOP_IN_IDLE_BIT] = ctrl_q.stop_in_idle;
    ctrl_word[`RTC_SEL_BIT] = ctrl_q.sel;
    ctrl_word[`RTC_RUN_BIT] = stat.running; // [RULE_09]
    ctrl_word[`RTC_WREN_BIT] = ctrl_q.wren;
    ctrl_word[`RTC_SYNC_BIT] = stat.sync; // [RULE_12]
    ctrl_word[`RTC_HALF_BIT] = stat.half; // [RULE_14]
    ctrl_word[`RTC_OE_BIT] = ctrl_q.oe;
  end

  // data stand for the one cycle after the read strobe only; unmapped reads give zero
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_q <= '0;
    else if (i_rd && i_addr == ADDR_W'(`RTC_CTRL_OFS))
      rdata_q <= ctrl_word;
    else
      rdata_q <= '0;
  end

  assign o_rdata = rdata_q;

  // ************************************************************
  // time value write gating
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      time_wr_q <= 1'b0;
      time_wdata_q <= '0;
    end
    else
    begin
      time_wr_q <= time_wr && ctrl_q.wren; // [RULE_10]
      if (time_wr && ctrl_q.wren)
        time_wdata_q <= i_wdata;
    end
  end

  assign o_time_wr = time_wr_q;
  assign o_time_wdata = time_wdata_q;

  // ************************************************************
  // time base
  // ************************************************************
  rtc_timebase u_timebase (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_enable(ctrl_q.on),
    .i_cal(ctrl_q.cal),
    .i_sec_clear(sec_clear),
    .i_tick(i_xtal_tick),
    .o_corr_tick(o_corr_tick),
    .o_minute(o_minute),
    .o_stat(stat)
  );

  // ************************************************************
  // unit enable, idle gating and output pin
  // ************************************************************
  assign o_unit_enable = ctrl_q.on; // [RULE_04]
  // the crystal side keeps counting; only the bus-side clock is cut
  assign o_bus_clk_enable = !(i_idle && ctrl_q.stop_in_idle); // [RULE_06]

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pin_q <= 1'b0;
    else if (!ctrl_q.oe)
      pin_q <= 1'b0; // [RULE_08]
    else
      pin_q <= ctrl_q.sel ? stat.sec_clk : i_alarm_pulse; // [RULE_07]
  end

  assign o_rtc_pin = pin_q;

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_route_secs;
    ctrl_q.oe && ctrl_q.sel;
  endsequence

  sequence s_route_alarm;
    ctrl_q.oe && !ctrl_q.sel;
  endsequence

  sequence s_locked_on_write;
    ctrl_wr && !ctrl_q.wren;
  endsequence

  on_guard_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_05]
    s_locked_on_write |=> $stable(ctrl_q.on))
    else $error("enable changed while value writes locked");

  wren_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_11]
    ctrl_wr && i_wdata[`RTC_WREN_BIT] && !i_unlock && !ctrl_q.wren |=> !ctrl_q.wren)
    else $error("write enable set without unlock");

  wren_unlocked_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_11]
    ctrl_wr && i_wdata[`RTC_WREN_BIT] && i_unlock |=> ctrl_q.wren)
    else $error("write enable not set with unlock");

  pin_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_08]
    !ctrl_q.oe |=> !o_rtc_pin)
    else $error("pin active with output disabled");

  pin_secs_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_07]
    s_route_secs |=> o_rtc_pin == $past(stat.sec_clk))
    else $error("pin does not follow seconds clock");

  pin_alarm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_07]
    s_route_alarm |=> o_rtc_pin == $past(i_alarm_pulse))
    else $error("pin does not follow alarm pulse");

  idle_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_06]
    i_idle && ctrl_q.stop_in_idle |-> !o_bus_clk_enable)
    else $error("bus clock running in idle with stop set");

  reserved_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_17]
    i_rd |=> o_rdata[31:26] == 6'h00 && o_rdata[14] == 1'b0 &&
             o_rdata[12:8] == 5'h00 && o_rdata[5:4] == 2'h0)
    else $error("unimplemented bits read nonzero");

  time_lock_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_10]
    time_wr && !ctrl_q.wren |=> !o_time_wr)
    else $error("time write passed while locked");

  cal_store_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_01]
    ctrl_wr |=> ctrl_q.cal == $past(i_wdata[`RTC_CAL_MSB:`RTC_CAL_LSB]))
    else $error("calibration field not stored");

  unit_on_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_04]
    o_unit_enable == ctrl_q.on && (ctrl_q.on || !o_corr_tick))
    else $error("unit enable does not follow enable flag");

endmodule

// file: hw/rtc_pkg.sv
// types shared by the clock-and-calendar control block and its time base
package rtc_pkg;

  // software-visible control fields
  typedef struct packed {
    logic [9:0] cal;
    logic on;
    logic stop_in_idle;
    logic sel;
    logic wren;
    logic oe;
  } rtc_ctrl_s;

  // state reported by the time base
  typedef struct packed {
    logic running;
    logic sync;
    logic half;
    logic sec_clk;
  } rtc_stat_s;

  // calibration sequencer, gray coded
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_ADD = 2'b01,
    CAL_DROP = 2'b11
  } cal_state_e;

endpackage

// file: hw/rtc_timebase.sv
// corrected time base: drift calibration, half-second and rollover flags
`include "rtc_cfg.svh"

module rtc_timebase #(
  parameter int TICKS_PER_SEC = `RTC_XTAL_HZ,
  parameter int SEC_PER_MIN = `RTC_SEC_PER_MIN,
  parameter int SYNC_WINDOW = `RTC_SYNC_WINDOW,
  parameter int TIMEOUT_CYC = `RTC_XTAL_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_enable,
  input wire logic [9:0] i_cal,
  input wire logic i_sec_clear,
  // crystal tick, one cycle per crystal period
  input wire logic i_tick,
  // results
  output logic o_corr_tick,
  output logic o_minute,
  output rtc_pkg::rtc_stat_s o_stat
);

  localparam int SUB_W = $clog2(TICKS_PER_SEC);
  localparam int SEC_W = $clog2(SEC_PER_MIN);
  localparam int TO_W = $clog2(TIMEOUT_CYC + 1);
  localparam logic [SUB_W-1:0] SUB_MAX = SUB_W'(TICKS_PER_SEC - 1);
  localparam logic [SUB_W-1:0] SYNC_FROM = SUB_W'(TICKS_PER_SEC - SYNC_WINDOW);
  localparam logic [SEC_W-1:0] SEC_MAX = SEC_W'(SEC_PER_MIN - 1);
  localparam logic [TO_W-1:0] TO_MAX = TO_W'(TIMEOUT_CYC);

  logic [SUB_W-1:0] sub_q;
  logic [SEC_W-1:0] sec_q;
  logic [9:0] cnt_q;
  logic [TO_W-1:0] idle_q;
  rtc_pkg::cal_state_e st_q;
  logic sub_wrap;

  // ************************************************************
  // corrected tick: extra pulses fill gaps, dropped ones are swallowed
  // ************************************************************
  assign o_corr_tick = i_enable && ((i_tick && st_q != rtc_pkg::CAL_DROP) ||
                                    (!i_tick && st_q == rtc_pkg::CAL_ADD)); // [RULE_18]
  assign sub_wrap = o_corr_tick && sub_q == SUB_MAX;
  assign o_minute = sub_wrap && sec_q == SEC_MAX;

  // sub-second count; a seconds write restarts the second
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      sub_q <= '0;
    else if (i_sec_clear)
      sub_q <= '0; // [RULE_15]
    else if (o_corr_tick)
      sub_q <= sub_q + SUB_W'(1);
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      sec_q <= '0;
    else if (sub_wrap)
      sec_q <= (sec_q == SEC_MAX) ? '0 : sec_q + SEC_W'(1);
  end

  // ************************************************************
  // calibration sequencer, loaded once a minute
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q <= rtc_pkg::CAL_IDLE;
      cnt_q <= '0;
    end
    else if (o_minute && $signed(i_cal) > 0)
    begin
      st_q <= rtc_pkg::CAL_ADD; // [RULE_02]
      cnt_q <= i_cal;
    end
    else if (o_minute && $signed(i_cal) < 0)
    begin
      st_q <= rtc_pkg::CAL_DROP; // [RULE_03]
      cnt_q <= 10'(-i_cal);
    end
    else
    begin
      unique case (st_q)
        rtc_pkg::CAL_IDLE: ;
        rtc_pkg::CAL_ADD:
          if (i_enable && !i_tick)
          begin
            cnt_q <= cnt_q - 10'h001;
            if (cnt_q == 10'h001)
              st_q <= rtc_pkg::CAL_IDLE;
          end
        rtc_pkg::CAL_DROP:
          if (i_enable && i_tick)
          begin
            cnt_q <= cnt_q - 10'h001;
            if (cnt_q == 10'h001)
              st_q <= rtc_pkg::CAL_IDLE;
          end
        default: st_q <= rtc_pkg::CAL_IDLE;
      endcase
    end
  end

  // crystal presence: a few missed periods mean the clock has stopped
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      idle_q <= TO_MAX;
    else if (i_tick)
      idle_q <= '0;
    else if (idle_q != TO_MAX)
      idle_q <= idle_q + TO_W'(1);
  end

  assign o_stat.running = idle_q != TO_MAX; // [RULE_09]
  assign o_stat.half = sub_q[SUB_W-1]; // [RULE_14]
  assign o_stat.sync = i_enable && sub_q >= SYNC_FROM; // [RULE_12]
  assign o_stat.sec_clk = sub_q[SUB_W-1];

  // ************************************************************
  // checks
  // ************************************************************
  half_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_15]
    i_sec_clear |=> !o_stat.half)
    else $error("half-second flag not cleared by seconds write");

  drop_swallow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_03]
    st_q == rtc_pkg::CAL_DROP |-> !o_corr_tick)
    else $error("tick passed while dropping");

  add_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_02]
    o_minute && $signed(i_cal) > 0 |=> st_q == rtc_pkg::CAL_ADD && cnt_q == $past(i_cal))
    else $error("positive calibration not loaded");

endmodule

// file: sim/tb_top.sv
// self-checking testbench for the clock-and-calendar control block
`include "rtc_cfg.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // signals and instance
  // ************************************************************
  localparam logic [31:0] WREN = 32'h0000_0008;
  localparam logic [31:0] ON = 32'h0000_8000;
  localparam logic [31:0] RW_MASK = 32'h03ff_a089;
  localparam logic [31:0] RO_MASK = 32'h0000_0046;

  logic i_clk;
  logic i_rst_n;
  logic [7:0] i_addr;
  logic [31:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [31:0] o_rdata;
  logic i_xtal_tick;
  logic i_unlock;
  logic i_idle;
  logic i_alarm_pulse;
  logic o_unit_enable;
  logic o_bus_clk_enable;
  logic o_corr_tick;
  logic o_minute;
  logic o_time_wr;
  logic [31:0] o_time_wdata;
  logic o_rtc_pin;
  int n_errors;
  int tests_run;

  rtc_control_calibration #(
    .ADDR_W(8)
  ) rtc_control_calibration_i (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_xtal_tick(i_xtal_tick),
    .i_unlock(i_unlock),
    .i_idle(i_idle),
    .i_alarm_pulse(i_alarm_pulse),
    .o_unit_enable(o_unit_enable),
    .o_bus_clk_enable(o_bus_clk_enable),
    .o_corr_tick(o_corr_tick),
    .o_minute(o_minute),
    .o_time_wr(o_time_wr),
    .o_time_wdata(o_time_wdata),
    .o_rtc_pin(o_rtc_pin)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    logic [31:0] d;
    rd(`RTC_CTRL_OFS, d);
    chk(d, 32'h0000_0000, "ctrl after reset");
    chk({31'h0, o_unit_enable}, 32'h0, "enable after reset");
    chk({31'h0, o_rtc_pin}, 32'h0, "pin after reset");
    rd(8'h08, d);
    chk(d, 32'h0000_0000, "unmapped read");
    $display("test reset done");
  endtask

  task automatic t_guards();
    logic [31:0] d;
    i_unlock <= 1'b0;
    wr(`RTC_CTRL_OFS, ON | WREN);
    rd(`RTC_CTRL_OFS, d);
    chk(d, 32'h0, "set while locked");
    i_unlock <= 1'b1;
    wr(`RTC_CTRL_OFS, ON | WREN);
    rd(`RTC_CTRL_OFS, d);
    chk(d & RW_MASK, WREN, "enable needs prior wren");
    wr(`RTC_CTRL_OFS, ON | WREN);
    rd(`RTC_CTRL_OFS, d);
    chk(d & RW_MASK, ON | WREN, "enable accepted");
    chk({31'h0, o_unit_enable}, 32'h1, "unit on");
    wr(`RTC_CTRL_OFS, WREN);
    #1 chk({31'h0, o_unit_enable}, 32'h0, "unit off");
    // leave the bus quiet for a cycle after clearing the enable flag
    @(posedge i_clk);
    $display("test guards done");
  endtask

  task automatic t_fields();
    logic [31:0] d;
    logic [9:0] codes [5] = '{10'h1ff, 10'h001, 10'h000, 10'h3ff, 10'h200};
    wr(`RTC_CTRL_OFS, 32'hffff_ffff);
    rd(`RTC_CTRL_OFS, d);
    chk(d & ~RO_MASK, RW_MASK, "all ones readback");
    // the per-minute pulse effect needs about two million ticks, too long here
    foreach (codes[k])
    begin
      wr(`RTC_CTRL_OFS, WREN | {6'h0, codes[k], 16'h0});
      rd(`RTC_CTRL_OFS, d);
      chk({22'h0, d[25:16]}, {22'h0, codes[k]}, "cal code");
    end
    $display("test fields done");
  endtask

  task automatic t_idle();
    wr(`RTC_CTRL_OFS, WREN | 32'h0000_2000);
    i_idle <= 1'b1;
    @(posedge i_clk);
    #1 chk({31'h0, o_bus_clk_enable}, 32'h0, "bus clock cut");
    wr(`RTC_CTRL_OFS, WREN);
    #1 chk({31'h0, o_bus_clk_enable}, 32'h1, "bus clock kept");
    i_idle <= 1'b0;
    $display("test idle done");
  endtask

  task automatic t_pin();
    i_alarm_pulse <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 chk({31'h0, o_rtc_pin}, 32'h0, "pin off");
    wr(`RTC_CTRL_OFS, WREN | 32'h0000_0001);
    @(posedge i_clk);
    #1 chk({31'h0, o_rtc_pin}, 32'h1, "alarm on pin");
    i_alarm_pulse <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1 chk({31'h0, o_rtc_pin}, 32'h0, "alarm low");
    $display("test pin done");
  endtask

  task automatic t_running();
    logic [31:0] d;
    i_xtal_tick <= 1'b1;
    repeat (10) @(posedge i_clk);
    rd(`RTC_CTRL_OFS, d);
    chk({31'h0, d[6]}, 32'h1, "base running");
    i_xtal_tick <= 1'b0;
    repeat (`RTC_XTAL_TIMEOUT_CYC + 100) @(posedge i_clk);
    rd(`RTC_CTRL_OFS, d);
    chk({31'h0, d[6]}, 32'h0, "base stopped");
    $display("test running done");
  endtask

  task automatic t_time();
    wr(`RTC_CTRL_OFS, 32'h0);
    wr(`RTC_TIME_OFS, 32'h0000_1234);
    #1 chk({31'h0, o_time_wr}, 32'h0, "locked time write");
    wr(`RTC_CTRL_OFS, WREN);
    wr(`RTC_TIME_OFS, 32'h0012_3a00);
    #1 chk({31'h0, o_time_wr}, 32'h1, "time write strobe");
    chk(o_time_wdata, 32'h0012_3a00, "time write data");
    @(posedge i_clk);
    #1 chk({31'h0, o_time_wr}, 32'h0, "strobe one cycle");
    $display("test time done");
  endtask

  // seconds clock on the pin follows the half flag, so the pin shows bit 14 of the count
  task automatic t_half();
    logic [31:0] d;
    logic [31:0] d2;
    int n;
    wr(`RTC_CTRL_OFS, ON | WREN | 32'h0000_0081);
    i_xtal_tick <= 1'b1;
    wr(`RTC_TIME_OFS, 32'h0);
    #1 chk({31'h0, o_corr_tick}, 32'h1, "tick passes");
    rd(`RTC_CTRL_OFS, d);
    chk({30'h0, d[2:1]}, 32'h0, "first half safe");
    n = 0;
    while (o_rtc_pin !== 1'b1 && n < 20000)
    begin
      @(posedge i_clk);
      #1 n++;
    end
    chk({31'h0, (n > 16370 && n < 16400)}, 32'h1, "half after 16384 ticks");
    n = 0;
    d = 32'h0;
    while (d[2] !== 1'b1 && n < 12000)
    begin
      rd(`RTC_CTRL_OFS, d);
      n++;
    end
    chk({30'h0, d[2:1]}, 32'h3, "rollover window");
    rd(`RTC_CTRL_OFS, d2);
    chk({30'h0, d2[2:1]}, {30'h0, d[2:1]}, "second read agrees");
    wr(`RTC_TIME_OFS, 32'h0000_0500);
    rd(`RTC_CTRL_OFS, d);
    chk({30'h0, d[2:1]}, 32'h0, "seconds write clears");
    wr(`RTC_CTRL_OFS, WREN);
    #1 chk({31'h0, o_corr_tick}, 32'h0, "no tick when off");
    i_xtal_tick <= 1'b0;
    $display("test half done");
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial
  begin
    n_errors = 0;
    tests_run = 0;
    i_rst_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_xtal_tick = 1'b0;
    i_unlock = 1'b0;
    i_idle = 1'b0;
    i_alarm_pulse = 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_guards();
    t_fields();
    t_idle();
    t_pin();
    t_running();
    t_time();
    t_half();
    stop_test();
  end

  initial
  begin
    repeat (100000) @(posedge i_clk);
    n_errors++;
    $display("CHECK FAILED at %0t: run limit reached", $time);
    stop_test();
  end
endmodule
